// ==== hdl/ias_pkg.sv ====
package ias_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLOW_PERIOD = 8'h04;
  localparam logic [7:0] REG_CONV_TIME = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_SRC_PTR = 8'h14;
  localparam logic [7:0] REG_LUT_WR = 8'h18;
  localparam logic [7:0] REG_LAMP = 8'h1c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TARGET_BIT = 1;
  localparam int LUT_DATA_LSB = 16;
  localparam int LAMP_BATT_LSB = 8;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] PAGE_LIGHT = 8'hfb;
  localparam logic [7:0] PAGE_BATT = 8'hfa;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] LAMP_LIGHT_RST = 8'h01;
  localparam logic [7:0] LAMP_BATT_RST = 8'h02;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_TICK_MS = 500;
  localparam int SCAN_PERIOD_NS = 536000;
  localparam int FAST_TICK_NS = 134000;
  localparam int CONV_MIN_NS = 11375;
  localparam int CONV_MAX_NS = 77875;
  localparam int SETTLE_NS = 10000;
  localparam int SLOW_TICK_CYC = SLOW_TICK_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SLOW_MIN_CYC = (4 * SCAN_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_IDLE, C1_DISP, C1_LAMP, C1_REF, C1_CHAN, C1_SETTLE, C1_CMP, C1_WAKE, C1_TSTART,
    ST_WAIT_FAST, ST_WAIT_CONV, C2_CMPOFF, C2_REFWAKE, C2_RESULT, C2_LOW, C2_HIGH,
    C2_DIS, C2_PTR, C2_EN, C2_LAMP, C2_TSTOP, C2_TINIT
  } ias_state_t;

endpackage

// ==== hdl/ias_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE_01] Slow timer ticks periodically, default 500 ms; each tick starts chain one.
// [RULE_02] Slow period settable only above four scan periods of 536 us.
// [RULE_03] Fast timer of 134 us acts as converter hardware start via event link.
// [RULE_04] Converter measures light input or battery input per current target.
// [RULE_05] Conversion time defaults to 11.375 us, adjustable up to 77.875 us.
// [RULE_06] Chain one first copies looked-up segment word into display output.
// [RULE_07] Next it copies stored lamp word into display output.
// [RULE_08] Reference: analog supply for light, internal reference for battery.
// [RULE_09] Input channel selected per target: light or battery channel.
// [RULE_10] Dummy transfers give at least 10 us settling before arming.
// [RULE_11] Then enable comparator, then enable low-power wake operation.
// [RULE_12] Last step of chain one starts the fast timer.
// [RULE_13] Fast timer request starts conversion without waking the processor.
// [RULE_14] Conversion end starts chain two; first step disables comparator.
// [RULE_15] Chain two restores supply reference and disables low-power wake.
// [RULE_16] Chain two stores conversion result.
// [RULE_17] Upper result byte to pointer low byte; page FB or FA to high byte.
// [RULE_18] Disable slow tick, load control data 14 source, re-enable slow tick.
// [RULE_19] Chain two stores target lamp word into display storage.
// [RULE_20] Chain two stops fast timer and reinitialises its compare value; the code clears the fast counter fastCnt instead.
// [RULE_21] Whole cycle completes without any processor wake.
// [RULE_22] Each switch press toggles target between battery and light.
// [RULE_23] Transfers run strictly in order; a new chain waits for the current one.
module ias_sequencer #(
  parameter int unsigned SLOW_TICK_CYC = ias_pkg::SLOW_TICK_CYC,
  parameter int unsigned SLOW_MIN_CYC = ias_pkg::SLOW_MIN_CYC,
  parameter int unsigned FAST_TICK_CYC = ias_pkg::FAST_TICK_CYC,
  parameter int unsigned RES_W = 12
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic switchPin,
  input wire logic adcDone,
  input wire logic [RES_W-1:0] adcResult,
  output logic adcRefInternal,
  output logic adcChanLight,
  output logic adcCmpEn,
  output logic adcWakeEn,
  output logic adcStart,
  output logic [11:0] adcConvCycles,
  output logic [7:0] dispOut
);

  if (RES_W < 8 || RES_W > 16) $error("RES_W must be 8..16");
  if (SLOW_TICK_CYC <= SLOW_MIN_CYC) $error("SLOW_TICK_CYC must exceed SLOW_MIN_CYC");
  if (FAST_TICK_CYC < 2 || FAST_TICK_CYC > 65535) $error("FAST_TICK_CYC out of range");

  typedef struct packed {
    ias_pkg::ias_state_t st;
    logic [31:0] slowCnt;
    logic [31:0] slowPeriod;
    logic slowPending;
    logic slowTickEn;
    logic [15:0] fastCnt;
    logic fastRun;
    logic [9:0] settleCnt;
    logic enable;
    logic targetLight;
    logic swSync1;
    logic swSync2;
    logic swPrev;
    logic [11:0] convCycles;
    logic [7:0] dispOut;
    logic [7:0] dispStore;
    logic [7:0] lampLight;
    logic [7:0] lampBatt;
    logic [15:0] resultStore;
    logic [15:0] srcPtrVar;
    logic [15:0] ctrl14Src;
    logic adcRefInternal;
    logic adcChanLight;
    logic adcCmpEn;
    logic adcWakeEn;
    logic adcStart;
    logic awready;
    logic wready;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic lutWe;
    logic [8:0] lutIdx;
    logic [7:0] lutData;
  } ias_regs_t;

  ias_regs_t r;
  ias_regs_t next_r;
  logic [7:0] lut [0:511];
  logic [7:0] lutRead;
  logic [31:0] wordIn;
  logic [31:0] rdWord;
  logic rdOk;

  // ----------------------------------------
  // Display lookup table, pages FA and FB
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (r.lutWe)
      lut[r.lutIdx] <= r.lutData;
  end

  assign lutRead = lut[{r.ctrl14Src[15:8] == ias_pkg::PAGE_LIGHT, r.ctrl14Src[7:0]}];

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    return res;
  endfunction

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb
  begin
    rdOk = 1'b1;
    rdWord = 32'h0;
    case (s_axi_araddr)
      ias_pkg::REG_CTRL: rdWord = {30'h0, r.targetLight, r.enable};
      ias_pkg::REG_SLOW_PERIOD: rdWord = r.slowPeriod;
      ias_pkg::REG_CONV_TIME: rdWord = {20'h0, r.convCycles};
      ias_pkg::REG_STATUS: rdWord = {19'h0, r.slowTickEn, r.fastRun, r.adcWakeEn, r.adcCmpEn,
                                     r.targetLight, r.dispOut[2:0], r.st};
      ias_pkg::REG_RESULT: rdWord = {16'h0, r.resultStore};
      ias_pkg::REG_SRC_PTR: rdWord = {r.srcPtrVar, r.ctrl14Src};
      ias_pkg::REG_LUT_WR: rdWord = 32'h0;
      ias_pkg::REG_LAMP: rdWord = {16'h0, r.lampBatt, r.lampLight};
      default: rdOk = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    wordIn = 32'h0;
    next_r.adcStart = 1'b0;
    next_r.lutWe = 1'b0;

    // Switch input and toggle
    next_r.swSync1 = switchPin;
    next_r.swSync2 = r.swSync1;
    next_r.swPrev = r.swSync2;

    // AXI4-Lite write
    if (s_axi_awvalid && r.awready)
    begin
      next_r.awAddr = s_axi_awaddr;
      next_r.awHave = 1'b1;
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.wData = s_axi_wdata;
      next_r.wStrb = s_axi_wstrb;
      next_r.wHave = 1'b1;
      next_r.wready = 1'b0;
    end
    if (r.awHave && r.wHave && !r.bvalid)
    begin
      next_r.awHave = 1'b0;
      next_r.wHave = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = ias_pkg::RESP_OKAY;
      case (r.awAddr)
        ias_pkg::REG_CTRL:
        begin
          wordIn = mergeBytes({30'h0, r.targetLight, r.enable}, r.wData, r.wStrb);
          next_r.enable = wordIn[ias_pkg::CTRL_ENABLE_BIT];
          next_r.targetLight = wordIn[ias_pkg::CTRL_TARGET_BIT];
        end
        ias_pkg::REG_SLOW_PERIOD:
        begin
          wordIn = mergeBytes(r.slowPeriod, r.wData, r.wStrb);
          if (wordIn > SLOW_MIN_CYC) // RULE_02
            next_r.slowPeriod = wordIn;
          else
            next_r.bresp = ias_pkg::RESP_SLVERR;
        end
        ias_pkg::REG_CONV_TIME:
        begin
          wordIn = mergeBytes({20'h0, r.convCycles}, r.wData, r.wStrb);
          if (wordIn >= ias_pkg::CONV_MIN_CYC && wordIn <= ias_pkg::CONV_MAX_CYC) // RULE_05
            next_r.convCycles = wordIn[11:0];
          else
            next_r.bresp = ias_pkg::RESP_SLVERR;
        end
        ias_pkg::REG_LUT_WR:
        begin
          next_r.lutWe = 1'b1;
          next_r.lutIdx = {r.wData[15:8] == ias_pkg::PAGE_LIGHT, r.wData[7:0]};
          next_r.lutData = r.wData[ias_pkg::LUT_DATA_LSB +: 8];
        end
        ias_pkg::REG_LAMP:
        begin
          wordIn = mergeBytes({16'h0, r.lampBatt, r.lampLight}, r.wData, r.wStrb);
          next_r.lampLight = wordIn[7:0];
          next_r.lampBatt = wordIn[ias_pkg::LAMP_BATT_LSB +: 8];
        end
        ias_pkg::REG_STATUS, ias_pkg::REG_RESULT, ias_pkg::REG_SRC_PTR: ;
        default: next_r.bresp = ias_pkg::RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // AXI4-Lite read
    if (s_axi_arvalid && r.arready)
    begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rdWord;
      next_r.rresp = rdOk ? ias_pkg::RESP_OKAY : ias_pkg::RESP_SLVERR;
    end
    if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // Switch edge beats a same-cycle software write
    if (r.swSync2 && !r.swPrev)
      next_r.targetLight = !r.targetLight; // RULE_22

    // Slow interval timer
    if (r.slowCnt >= r.slowPeriod - 32'h1)
    begin
      next_r.slowCnt = 32'h0;
      if (r.slowTickEn && r.enable)
        next_r.slowPending = 1'b1; // RULE_01
    end
    else
      next_r.slowCnt = r.slowCnt + 32'h1;

    // Fast interval timer
    if (r.fastRun)
      next_r.fastCnt = r.fastCnt + 16'h1;

    // ----------------------------------------
    // Transfer chains
    // ----------------------------------------
    case (r.st)
      ias_pkg::ST_IDLE:
        if (r.slowPending && r.enable) // RULE_23
        begin
          next_r.st = ias_pkg::C1_DISP;
        end
      ias_pkg::C1_DISP:
      begin
        if (!(next_r.slowPending && !r.slowPending))
          next_r.slowPending = 1'b0;
        next_r.dispOut = lutRead; // RULE_06
        next_r.st = ias_pkg::C1_LAMP;
      end
      ias_pkg::C1_LAMP:
      begin
        next_r.dispOut = r.dispStore; // RULE_07
        next_r.st = ias_pkg::C1_REF;
      end
      ias_pkg::C1_REF:
      begin
        next_r.adcRefInternal = !r.targetLight; // RULE_08
        next_r.st = ias_pkg::C1_CHAN;
      end
      ias_pkg::C1_CHAN:
      begin
        next_r.adcChanLight = r.targetLight; // RULE_04 RULE_09
        next_r.settleCnt = 10'(ias_pkg::SETTLE_CYC - 1);
        next_r.st = ias_pkg::C1_SETTLE;
      end
      ias_pkg::C1_SETTLE:
        if (r.settleCnt == 10'h0)
          next_r.st = ias_pkg::C1_CMP;
        else
          next_r.settleCnt = r.settleCnt - 10'h1; // RULE_10
      ias_pkg::C1_CMP:
      begin
        next_r.adcCmpEn = 1'b1; // RULE_11
        next_r.st = ias_pkg::C1_WAKE;
      end
      ias_pkg::C1_WAKE:
      begin
        next_r.adcWakeEn = 1'b1; // RULE_11
        next_r.st = ias_pkg::C1_TSTART;
      end
      ias_pkg::C1_TSTART:
      begin
        next_r.fastRun = 1'b1; // RULE_12
        next_r.fastCnt = 16'h0;
        next_r.st = ias_pkg::ST_WAIT_FAST;
      end
      ias_pkg::ST_WAIT_FAST:
        if (r.fastCnt == 16'(FAST_TICK_CYC - 1))
        begin
          next_r.fastCnt = 16'h0;
          next_r.adcStart = r.adcWakeEn; // RULE_03 RULE_13
          next_r.st = ias_pkg::ST_WAIT_CONV;
        end
      ias_pkg::ST_WAIT_CONV:
        if (adcDone)
          next_r.st = ias_pkg::C2_CMPOFF;
      ias_pkg::C2_CMPOFF:
      begin
        next_r.adcCmpEn = 1'b0; // RULE_14
        next_r.st = ias_pkg::C2_REFWAKE;
      end
      ias_pkg::C2_REFWAKE:
      begin
        next_r.adcRefInternal = 1'b0; // RULE_15
        next_r.adcWakeEn = 1'b0;
        next_r.st = ias_pkg::C2_RESULT;
      end
      ias_pkg::C2_RESULT:
      begin
        next_r.resultStore = 16'(adcResult); // RULE_16
        next_r.st = ias_pkg::C2_LOW;
      end
      ias_pkg::C2_LOW:
      begin
        next_r.srcPtrVar[7:0] = r.resultStore[RES_W-1 -: 8]; // RULE_17
        next_r.st = ias_pkg::C2_HIGH;
      end
      ias_pkg::C2_HIGH:
      begin
        next_r.srcPtrVar[15:8] = r.targetLight ? ias_pkg::PAGE_LIGHT : ias_pkg::PAGE_BATT; // RULE_17
        next_r.st = ias_pkg::C2_DIS;
      end
      ias_pkg::C2_DIS:
      begin
        next_r.slowTickEn = 1'b0; // RULE_18
        next_r.st = ias_pkg::C2_PTR;
      end
      ias_pkg::C2_PTR:
      begin
        next_r.ctrl14Src = r.srcPtrVar; // RULE_18
        next_r.st = ias_pkg::C2_EN;
      end
      ias_pkg::C2_EN:
      begin
        next_r.slowTickEn = 1'b1; // RULE_18
        next_r.st = ias_pkg::C2_LAMP;
      end
      ias_pkg::C2_LAMP:
      begin
        next_r.dispStore = r.targetLight ? r.lampLight : r.lampBatt; // RULE_19
        next_r.st = ias_pkg::C2_TSTOP;
      end
      ias_pkg::C2_TSTOP:
      begin
        next_r.fastRun = 1'b0; // RULE_20
        next_r.st = ias_pkg::C2_TINIT;
      end
      ias_pkg::C2_TINIT:
      begin
        next_r.fastCnt = 16'h0; // RULE_20
        next_r.st = ias_pkg::ST_IDLE; // RULE_21
      end
      default: next_r.st = ias_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.st <= ias_pkg::ST_IDLE;
      r.slowPeriod <= SLOW_TICK_CYC;
      r.slowTickEn <= 1'b1;
      r.enable <= 1'b1;
      r.convCycles <= 12'(ias_pkg::CONV_MIN_CYC);
      r.lampLight <= ias_pkg::LAMP_LIGHT_RST;
      r.lampBatt <= ias_pkg::LAMP_BATT_RST;
      r.ctrl14Src <= {ias_pkg::PAGE_BATT, 8'h00};
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign adcRefInternal = r.adcRefInternal;
  assign adcChanLight = r.adcChanLight;
  assign adcCmpEn = r.adcCmpEn;
  assign adcWakeEn = r.adcWakeEn;
  assign adcStart = r.adcStart;
  assign adcConvCycles = r.convCycles;
  assign dispOut = r.dispOut;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [9:0] settleLen;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      settleLen <= 10'h0;
    else if (r.st == ias_pkg::C1_SETTLE)
      settleLen <= settleLen + 10'h1;
    else
      settleLen <= 10'h0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_TICK_START: assert property ((r.st == ias_pkg::ST_IDLE && r.slowPending && r.enable) |=> // RULE_01
    r.st == ias_pkg::C1_DISP ##1 r.st == ias_pkg::C1_LAMP) else $error("tick did not start chain");
  AST_PERIOD_MIN: assert property (r.slowPeriod > SLOW_MIN_CYC) else $error("slow period too short"); // RULE_02
  AST_FAST_TRIG: assert property ((r.st == ias_pkg::ST_WAIT_FAST && r.fastCnt == 16'(FAST_TICK_CYC - 1) // RULE_13
    && r.adcWakeEn) |=> adcStart && r.st == ias_pkg::ST_WAIT_CONV) else $error("no conversion start");
  AST_CONV_RANGE: assert property (adcConvCycles >= ias_pkg::CONV_MIN_CYC // RULE_05
    && adcConvCycles <= ias_pkg::CONV_MAX_CYC) else $error("conversion time out of range");
  AST_REF_CHAN: assert property (r.st == ias_pkg::C1_REF |=> adcRefInternal == !$past(r.targetLight) // RULE_08
    ##1 adcChanLight == $past(r.targetLight)) else $error("reference or channel wrong");
  AST_SETTLE: assert property (r.st == ias_pkg::C1_CMP |-> settleLen == 10'(ias_pkg::SETTLE_CYC) // RULE_10
    ##1 adcCmpEn ##1 adcWakeEn) else $error("settling or arming order wrong");
  AST_CMP_OFF: assert property ((r.st == ias_pkg::ST_WAIT_CONV && adcDone) |=> ##1 !adcCmpEn // RULE_14
    ##1 (!adcWakeEn && !adcRefInternal)) else $error("chain two start wrong");
  AST_PAGE: assert property (r.st == ias_pkg::C2_HIGH |=> r.srcPtrVar[15:8] == // RULE_17
    (r.targetLight ? ias_pkg::PAGE_LIGHT : ias_pkg::PAGE_BATT)) else $error("page byte wrong");
  AST_PTR: assert property (r.st == ias_pkg::C2_DIS |=> !r.slowTickEn ##1 // RULE_18
    (r.ctrl14Src == r.srcPtrVar && !r.slowTickEn) ##1 r.slowTickEn) else $error("source load wrong");
  AST_SWITCH: assert property ((r.swSync2 && !r.swPrev) |=> r.targetLight != $past(r.targetLight)) // RULE_22
    else $error("switch did not toggle target");
  AST_STOP: assert property (r.st == ias_pkg::C2_TSTOP |=> !r.fastRun ##1 // RULE_20
    (r.fastCnt == 16'h0 && r.st == ias_pkg::ST_IDLE)) else $error("fast timer not stopped");

  COV_FULL_CYCLE: cover property (r.st == ias_pkg::C2_TINIT);
  COV_SWITCH: cover property (r.swSync2 && !r.swPrev);
  COV_AXI_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_CONV_START: cover property (adcStart);

endmodule

`default_nettype wire

// ==== tb/ias_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Converter model: answers a start with a done pulse
// ----------------------------------------
module ias_adc_model #(
  parameter int DELAY = 30
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic adcStart,
  input wire logic [11:0] value,
  output logic adcDone,
  output logic [11:0] adcResult
);
  int cnt;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= -100;
      adcDone <= 1'b0;
      adcResult <= 12'h000;
    end
    else
    begin
      if (adcStart)
        cnt <= DELAY;
      else if (cnt > -20)
        cnt <= cnt - 1;
      adcDone <= (cnt == 1);
      // Result valid only near done, toggling otherwise
      adcResult <= (cnt <= 1 && cnt > -8) ? value : ~adcResult;
    end
  end
endmodule
`default_nettype wire

// ==== tb/intermittent_adc_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module intermittent_adc_sequencer_test;
  logic mclk, resetn, switchPin, adcDone, adcRefInternal, adcChanLight, adcCmpEn, adcWakeEn, adcStart;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dispOut;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] adcResult, adcConvCycles, adcValue;
  logic [7:0] hist [0:2];
  int errors, num_checks, cnt;

  ias_sequencer #(.SLOW_TICK_CYC(2000), .SLOW_MIN_CYC(100), .FAST_TICK_CYC(20)) DUT (
    .mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .switchPin(switchPin), .adcDone(adcDone), .adcResult(adcResult), .adcRefInternal(adcRefInternal),
    .adcChanLight(adcChanLight), .adcCmpEn(adcCmpEn), .adcWakeEn(adcWakeEn), .adcStart(adcStart),
    .adcConvCycles(adcConvCycles), .dispOut(dispOut));

  ias_adc_model #(.DELAY(30)) adcModel (.mclk(mclk), .resetn(resetn), .adcStart(adcStart),
    .value(adcValue), .adcDone(adcDone), .adcResult(adcResult));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Display history, one entry per cycle
  always @(posedge mclk)
  begin
    hist[2] <= hist[1];
    hist[1] <= hist[0];
    hist[0] <= dispOut;
  end

  task conclude;
    $display("Counts: errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic waitFor(ref logic s, input logic v);
    cnt = 1;
    @(negedge mclk);
    while (s !== v)
    begin
      @(negedge mclk);
      cnt++;
      if (cnt > 5000)
      begin
        errors++;
        conclude();
      end
    end
  endtask

  task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 200)
      begin
        errors++;
        conclude();
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task axiRead(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 200)
      begin
        errors++;
        conclude();
      end
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task resetValues;
    check("convCycles", {20'h0, adcConvCycles}, 32'h239);
    check("dispOut", {24'h0, dispOut}, 32'h0);
    axiRead(ias_pkg::REG_CTRL);
    check("ctrl", rd, 32'h1);
    axiRead(ias_pkg::REG_SLOW_PERIOD);
    check("slowPeriod", rd, 32'h7d0);
    axiRead(ias_pkg::REG_LAMP);
    check("lamp", rd, 32'h201);
    axiRead(ias_pkg::REG_SRC_PTR);
    check("srcPtr", {16'h0, rd[15:0]}, 32'hfa00);
  endtask

  task refusals;
    axiWrite(ias_pkg::REG_SLOW_PERIOD, 32'h64, ias_pkg::RESP_SLVERR);
    axiRead(ias_pkg::REG_SLOW_PERIOD);
    check("slowKept", rd, 32'h7d0);
    axiWrite(ias_pkg::REG_CONV_TIME, 32'h238, ias_pkg::RESP_SLVERR);
    axiWrite(ias_pkg::REG_CONV_TIME, 32'hf36, ias_pkg::RESP_SLVERR);
    axiWrite(ias_pkg::REG_CONV_TIME, 32'hf35, ias_pkg::RESP_OKAY);
    check("convMax", {20'h0, adcConvCycles}, 32'hf35);
    axiRead(8'h20);
    check("unmapData", rd, 32'h0);
    check("unmapResp", {30'h0, rsp}, {30'h0, ias_pkg::RESP_SLVERR});
    axiWrite(8'h24, 32'h1, ias_pkg::RESP_SLVERR);
    axiWrite(ias_pkg::REG_LAMP, 32'h403, ias_pkg::RESP_OKAY);
    axiRead(ias_pkg::REG_LAMP);
    check("lampWr", rd, 32'h403);
  endtask

  task measure(input logic light, input logic [7:0] lut, input logic [7:0] lamp, input logic [11:0] val,
               input logic [31:0] ptr);
    adcValue = val;
    if (light)
    begin
      waitFor(adcChanLight, 1'b1);
      check("dispLut", {24'h0, hist[2]}, {24'h0, lut});
    end
    else
    begin
      waitFor(adcRefInternal, 1'b1);
      check("dispLut", {24'h0, hist[1]}, {24'h0, lut});
    end
    check("dispLamp", {24'h0, dispOut}, {24'h0, lamp});
    check("refSel", {31'h0, adcRefInternal}, {31'h0, ~light});
    waitFor(adcCmpEn, 1'b1);
    check("chanSel", {31'h0, adcChanLight}, {31'h0, light});
    check("settle", {31'h0, cnt >= 500}, 32'h1);
    waitFor(adcStart, 1'b1);
    check("fastDelay", {31'h0, cnt >= 20 && cnt <= 24}, 32'h1);
    check("armed", {30'h0, adcCmpEn, adcWakeEn}, 32'h3);
    waitFor(adcCmpEn, 1'b0);
    check("wakeAfterCmp", {31'h0, adcWakeEn}, 32'h1);
    waitFor(adcWakeEn, 1'b0);
    check("refRestore", {31'h0, adcRefInternal}, 32'h0);
    repeat (30) @(negedge mclk);
    axiRead(ias_pkg::REG_RESULT);
    check("result", rd, {20'h0, val});
    axiRead(ias_pkg::REG_SRC_PTR);
    check("srcPtr", rd, ptr);
    axiRead(ias_pkg::REG_STATUS);
    check("stateIdle", {27'h0, rd[4:0]}, 32'h0);
    check("target", {31'h0, rd[8]}, {31'h0, light});
  endtask

  task pressSwitch;
    @(posedge mclk);
    switchPin <= 1'b1;
    repeat (4) @(posedge mclk);
    switchPin <= 1'b0;
    repeat (4) @(posedge mclk);
    axiRead(ias_pkg::REG_STATUS);
    check("toggle", {31'h0, rd[8]}, 32'h1);
  endtask

  initial
  begin
    {resetn, switchPin, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    adcValue = 12'h000;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    resetValues;
    refusals;
    axiWrite(ias_pkg::REG_LUT_WR, 32'h005afa00, ias_pkg::RESP_OKAY);
    axiWrite(ias_pkg::REG_LUT_WR, 32'h003cfaab, ias_pkg::RESP_OKAY);
    measure(1'b0, 8'h5a, 8'h00, 12'hab5, 32'hfaabfaab);
    pressSwitch;
    measure(1'b1, 8'h3c, 8'h04, 12'h7f0, 32'hfb7ffb7f);
    conclude;
  end
endmodule
`default_nettype wire
